// ===== rtl/irq_cpu_end.sv
// Processor-side end of the interrupt link: accepts requests,
// acknowledges, supplies branch target, keeps the return-address stack.
// Assumes the core's pc and return strobe come from logic on mclk.
`timescale 1ns/10ps
module irq_cpu_end
    import irq_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    irq_link_if.cpu link,
    input wire logic instr_boundary,
    input wire irq_pkg::addr_t next_pc,
    input wire logic reti_exec,
    output logic branch_valid,
    output irq_pkg::addr_t branch_addr,
    output irq_pkg::vec_t branch_vec,
    output logic return_valid,
    output irq_pkg::addr_t return_pc,
    output irq_pkg::depth_t nest_depth
);
    import irq_pkg::*;

    logic ack_r;
    cnt_t hold_r;
    logic reti_r;
    logic branch_valid_r;
    addr_t branch_addr_r;
    vec_t branch_vec_r;
    logic return_valid_r;
    addr_t return_pc_r;
    depth_t depth_r;
    addr_t pc_stack_r [NEST_DEPTH];
    logic accept;
    logic pop;

    // ****************************************************************
    // Acknowledge and branch
    // ****************************************************************
    // Taken only at an instruction boundary, so it completes first
    assign accept = link.irq_req && !ack_r && instr_boundary
        && depth_r != DEPTH_FULL;
    assign pop = reti_exec && depth_r != DEPTH_ZERO;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
            hold_r <= '0;
            branch_valid_r <= 1'b0;
            branch_addr_r <= '0;
            branch_vec_r <= '0;
        end else begin
            branch_valid_r <= accept;
            if (accept) begin
                ack_r <= 1'b1;
                hold_r <= CNT_W'(1);
                branch_addr_r <= link.isr_addr;
                branch_vec_r <= link.irq_num;
            end else if (ack_r) begin
                if (hold_r == CNT_W'(ACK_HOLD_CYC)) begin
                    ack_r <= 1'b0;
                end else begin
                    hold_r <= hold_r + CNT_W'(1);
                end
            end
        end
    end

    // ****************************************************************
    // Return-address stack
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            depth_r <= DEPTH_ZERO;
            reti_r <= 1'b0;
            return_valid_r <= 1'b0;
            return_pc_r <= '0;
            for (int i = 0; i < NEST_DEPTH; i++) begin
                pc_stack_r[i] <= '0;
            end
        end else begin
            reti_r <= pop;
            return_valid_r <= pop;
            if (accept) begin
                pc_stack_r[depth_r[CNT_W-1:0]] <= next_pc;
                depth_r <= depth_r + DEPTH_W'(1);
            end else if (pop) begin
                return_pc_r <= pc_stack_r[depth_r[CNT_W-1:0] - CNT_W'(1)];
                depth_r <= depth_r - DEPTH_W'(1);
            end
        end
    end

    assign link.request_acknowledge = ack_r;
    assign link.reti = reti_r;
    assign branch_valid = branch_valid_r;
    assign branch_addr = branch_addr_r;
    assign branch_vec = branch_vec_r;
    assign return_valid = return_valid_r;
    assign return_pc = return_pc_r;
    assign nest_depth = depth_r;

endmodule : irq_cpu_end

// ===== rtl/irq_ctrl.sv
// Vectored interrupt controller: source select, pending/posted flags,
// priority arbitration with nesting, request/acknowledge to the core.
// Assumes source lines are asynchronous; configuration ports are quasi-
// static and come from logic on mclk.
`timescale 1ns/10ps
module irq_ctrl
    import irq_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    irq_link_if.ctrl link,
    input wire logic [NUM_VEC-1:0] fixed_lines,
    input wire logic [HALF_VEC-1:0] dma_terminal_low_bus,
    input wire logic [HALF_VEC-1:0] dma_terminal_high_bus,
    input wire logic [NUM_VEC-1:0] logic_array_bus,
    input wire logic [NUM_VEC-1:0] vec_enable,
    input wire irq_pkg::src_t [NUM_VEC-1:0] vec_source,
    input wire irq_pkg::prio_t [NUM_VEC-1:0] vec_prio,
    input wire irq_pkg::addr_t [NUM_VEC-1:0] vec_addr,
    input wire logic [NUM_VEC-1:0] sw_set,
    input wire logic [NUM_VEC-1:0] sw_clear,
    output logic [NUM_VEC-1:0] pending_flag,
    output logic [NUM_VEC-1:0] posted_flag,
    output irq_pkg::depth_t active_depth,
    output irq_pkg::prio_t active_prio,
    output logic routine_complete
);
    import irq_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_EVAL = 4'h2,
        ST_REQ = 4'h4,
        ST_ACK = 4'h8
    } state_e;

    state_e state_r;
    cnt_t eval_cnt_r;
    logic [NUM_VEC-1:0] raw_src;
    logic [NUM_VEC-1:0] sync1_r;
    logic [NUM_VEC-1:0] sync2_r;
    logic [NUM_VEC-1:0] sync3_r;
    logic [NUM_VEC-1:0] pending_r;
    logic [NUM_VEC-1:0] posted_r;
    logic [NUM_VEC-1:0] ack_clr;
    logic [NUM_VEC-1:0] eligible;
    logic any_elig;
    vec_t win_vec;
    prio_t win_prio;
    prio_t win_prio_r;
    logic irq_req_r;
    vec_t irq_num_r;
    addr_t isr_addr_r;
    depth_t depth_r;
    prio_t cur_prio_r;
    prio_t prio_stack_r [NEST_DEPTH];
    logic complete_r;
    logic take_ack;
    logic do_pop;

    // ****************************************************************
    // Source selection and synchronisation
    // ****************************************************************
    always_comb begin
        for (int i = 0; i < NUM_VEC; i++) begin
            raw_src[i] = 1'b0;
            if (vec_source[i] == SRC_FIXED) begin
                raw_src[i] = fixed_lines[i];
            end else if (vec_source[i] == SRC_DMA) begin
                if (i < HALF_VEC) begin
                    raw_src[i] = dma_terminal_low_bus[i % HALF_VEC];
                end else begin
                    raw_src[i] = dma_terminal_high_bus[i % HALF_VEC];
                end
            end else if (vec_source[i] == SRC_ARRAY) begin
                // Array line is the route for any source to any vector
                raw_src[i] = logic_array_bus[i];
            end
        end
    end

    // Sources are asynchronous: two flops, third flop for edge only
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end else begin
            sync1_r <= raw_src;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // ****************************************************************
    // Pending and posted flags
    // ****************************************************************
    always_comb begin
        ack_clr = '0;
        if (take_ack) begin
            ack_clr[irq_num_r] = 1'b1;
        end
    end

    // Set beats clear so a trigger in the clearing cycle is kept
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pending_r <= '0;
        end else begin
            pending_r <= (pending_r & ~(sw_clear | ack_clr))
                | (sync2_r & ~sync3_r)
                | sw_set;
        end
    end

    // Posted trails pending by one clock, so it also clears after it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            posted_r <= '0;
        end else begin
            posted_r <= pending_r;
        end
    end

    // ****************************************************************
    // Arbitration
    // ****************************************************************
    always_comb begin
        for (int i = 0; i < NUM_VEC; i++) begin
            eligible[i] = posted_r[i] && pending_r[i] && vec_enable[i]
                && (depth_r == DEPTH_ZERO
                    || (depth_r != DEPTH_FULL
                        && vec_prio[i] < cur_prio_r));
        end
    end

    // Downward scan with <= leaves the lowest number on a tie
    always_comb begin
        any_elig = 1'b0;
        win_vec = '0;
        win_prio = PRIO_LOWEST;
        for (int i = NUM_VEC - 1; i >= 0; i--) begin
            if (eligible[i] && (!any_elig || vec_prio[i] <= win_prio)) begin
                any_elig = 1'b1;
                win_vec = VEC_W'(i);
                win_prio = vec_prio[i];
            end
        end
    end

    assign take_ack = (state_r == ST_REQ) && link.request_acknowledge;
    assign do_pop = link.reti && (depth_r != DEPTH_ZERO);

    // ****************************************************************
    // Request sequence
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            eval_cnt_r <= '0;
            irq_req_r <= 1'b0;
            irq_num_r <= '0;
            isr_addr_r <= '0;
            win_prio_r <= PRIO_LOWEST;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (any_elig) begin
                        eval_cnt_r <= CNT_W'(1);
                        state_r <= ST_EVAL;
                    end
                end
                ST_EVAL: begin
                    if (eval_cnt_r == CNT_W'(EVAL_CYC - 1)) begin
                        if (any_elig) begin
                            irq_req_r <= 1'b1;
                            irq_num_r <= win_vec;
                            isr_addr_r <= vec_addr[win_vec];
                            win_prio_r <= win_prio;
                            state_r <= ST_REQ;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end else begin
                        eval_cnt_r <= eval_cnt_r + CNT_W'(1);
                    end
                end
                ST_REQ: begin
                    if (link.request_acknowledge) begin
                        irq_req_r <= 1'b0;
                        state_r <= ST_ACK;
                    end else if (!pending_r[irq_num_r]) begin
                        // Cleared by software before acceptance
                        irq_req_r <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                end
                ST_ACK: begin
                    if (!link.request_acknowledge) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    irq_req_r <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Nesting stack of active priorities
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            depth_r <= DEPTH_ZERO;
            cur_prio_r <= PRIO_LOWEST;
            complete_r <= 1'b0;
            for (int i = 0; i < NEST_DEPTH; i++) begin
                prio_stack_r[i] <= PRIO_LOWEST;
            end
        end else begin
            complete_r <= do_pop;
            if (take_ack) begin
                prio_stack_r[depth_r[CNT_W-1:0]] <= cur_prio_r;
                cur_prio_r <= win_prio_r;
                depth_r <= depth_r + DEPTH_W'(1);
            end else if (do_pop) begin
                // Restore status from before the finished routine
                cur_prio_r <= prio_stack_r[depth_r[CNT_W-1:0] - CNT_W'(1)];
                depth_r <= depth_r - DEPTH_W'(1);
            end
        end
    end

    assign link.irq_req = irq_req_r;
    assign link.irq_num = irq_num_r;
    assign link.isr_addr = isr_addr_r;
    assign pending_flag = pending_r;
    assign posted_flag = posted_r;
    assign active_depth = depth_r;
    assign active_prio = cur_prio_r;
    assign routine_complete = complete_r;

endmodule : irq_ctrl

// ===== rtl/irq_link_if.sv
// Link between the interrupt controller and the processor-side end.
// Assumes both ends share mclk; no clocking block.
`timescale 1ns/10ps
interface irq_link_if;
    import irq_pkg::*;
    logic irq_req;
    vec_t irq_num;
    addr_t isr_addr;
    logic request_acknowledge;
    logic reti;

    modport ctrl (
        output irq_req,
        output irq_num,
        output isr_addr,
        input request_acknowledge,
        input reti
    );
    modport cpu (
        input irq_req,
        input irq_num,
        input isr_addr,
        output request_acknowledge,
        output reti
    );
endinterface : irq_link_if

// ===== rtl/irq_pkg.sv
// Shared constants and types for the vectored interrupt controller
// and its processor-side end. Both ends run on one clock, mclk.
package irq_pkg;
    localparam int NUM_VEC = 32;
    localparam int HALF_VEC = 16;
    localparam int VEC_W = 5;
    localparam int PRIO_W = 3;
    localparam int ADDR_W = 16;
    localparam int NEST_DEPTH = 8;
    localparam int DEPTH_W = 4;
    // Priority evaluation and acknowledge hold, in mclk cycles
    localparam int EVAL_CYC = 3;
    localparam int ACK_HOLD_CYC = 7;
    localparam int CNT_W = 3;

    typedef logic [VEC_W-1:0] vec_t;
    typedef logic [PRIO_W-1:0] prio_t;
    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [DEPTH_W-1:0] depth_t;
    typedef logic [CNT_W-1:0] cnt_t;

    // Source selector codes
    typedef logic [1:0] src_t;
    localparam src_t SRC_FIXED = 2'h0;
    localparam src_t SRC_DMA = 2'h1;
    localparam src_t SRC_ARRAY = 2'h2;

    localparam prio_t PRIO_LOWEST = 3'h7;
    localparam depth_t DEPTH_ZERO = 4'h0;
    localparam depth_t DEPTH_FULL = 4'h8;
endpackage : irq_pkg

// ===== tb/irq_link_checker.sv
// Assertions on the controller-to-core link.
// Assumes the bench feeds it the link signals, mclk and rst by name.
`timescale 1ns/10ps
module irq_link_checker
    import irq_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic irq_req,
    input wire irq_pkg::vec_t irq_num,
    input wire irq_pkg::addr_t isr_addr,
    input wire logic request_acknowledge,
    input wire logic reti
);
    import irq_pkg::*;
    // ****************
    // Handshake
    // ****************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    sequence ack_taken;
        $rose(request_acknowledge);
    endsequence
    sequence ack_held;
        request_acknowledge [*7] ##1 !request_acknowledge;
    endsequence
    ack_hold_a: assert property (ack_taken |-> ack_held)
        else $error("acknowledge not held seven cycles");
    ack_cause_a: assert property (ack_taken |-> $past(irq_req))
        else $error("acknowledge without a request");
    req_drop_a: assert property (ack_taken |-> ##[0:2] !irq_req)
        else $error("request kept after acknowledge");
    req_quiet_a: assert property (ack_taken |-> ##2 !irq_req [*6])
        else $error("request raised during acknowledge");
    req_steady_a: assert property (irq_req && $past(irq_req)
        |-> $stable(irq_num) && $stable(isr_addr))
        else $error("vector or address moved under request");
    req_alone_a: assert property ($rose(irq_req)
        |-> !request_acknowledge)
        else $error("request raised while acknowledged");
    eval_gap_a: assert property ($fell(request_acknowledge)
        |-> !irq_req [*2])
        else $error("request skipped evaluation");
    ack_prompt_a: assert property ($rose(irq_req)
        |-> ##[1:40] (request_acknowledge || !irq_req))
        else $error("request never acknowledged");
endmodule : irq_link_checker

// ===== tb/vectored_interrupt_controller_bench.sv
// Bench: controller and processor end joined by the link interface.
// Assumes one clock; expected vectors come from vec_addr and next_pc.
`timescale 1ns/10ps
module vectored_interrupt_controller_bench;
    import irq_pkg::*;
    // ****************
    // Signals
    // ****************
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [NUM_VEC-1:0] fixed_lines = '0;
    logic [NUM_VEC-1:0] logic_array_bus = '0;
    logic [HALF_VEC-1:0] dma_terminal_low_bus = '0;
    logic [HALF_VEC-1:0] dma_terminal_high_bus = '0;
    logic [NUM_VEC-1:0] vec_enable = '1;
    logic [NUM_VEC-1:0] sw_set = '0;
    logic [NUM_VEC-1:0] sw_clear = '0;
    src_t [NUM_VEC-1:0] vec_source = '1;
    prio_t [NUM_VEC-1:0] vec_prio = '1;
    addr_t [NUM_VEC-1:0] vec_addr = '0;
    logic instr_boundary = 1'b0;
    logic reti_exec = 1'b0;
    addr_t next_pc = '0;
    logic [NUM_VEC-1:0] pending_flag;
    logic [NUM_VEC-1:0] posted_flag;
    logic branch_valid;
    logic return_valid;
    addr_t branch_addr;
    addr_t return_pc;
    vec_t branch_vec;
    depth_t active_depth;
    prio_t active_prio;
    logic routine_complete;
    depth_t nest_depth;
    logic [10:0] status_now;
    logic [20:0] branch_now;
    int fail_count = 0;
    int samples_checked = 0;
    int back = 0;
    int edge_v[4] = '{0, 15, 16, 31};
    logic [20:0] exp_q[$];
    addr_t ret_q[$];
    addr_t pc_stk[$];
    prio_t act_stk[$];
    logic [20:0] done_q[$];
    irq_link_if link ();
    irq_ctrl irq_ctrl_inst (.mclk(mclk), .rst(rst), .link(link),
        .fixed_lines(fixed_lines),
        .dma_terminal_low_bus(dma_terminal_low_bus),
        .dma_terminal_high_bus(dma_terminal_high_bus),
        .logic_array_bus(logic_array_bus), .vec_enable(vec_enable),
        .vec_source(vec_source), .vec_prio(vec_prio), .vec_addr(vec_addr),
        .sw_set(sw_set), .sw_clear(sw_clear), .pending_flag(pending_flag),
        .posted_flag(posted_flag), .active_depth(active_depth),
        .active_prio(active_prio), .routine_complete(routine_complete));
    irq_cpu_end irq_cpu_end_inst (.mclk(mclk), .rst(rst), .link(link),
        .instr_boundary(instr_boundary), .next_pc(next_pc),
        .reti_exec(reti_exec), .branch_valid(branch_valid),
        .branch_addr(branch_addr), .branch_vec(branch_vec),
        .return_valid(return_valid), .return_pc(return_pc),
        .nest_depth(nest_depth));
    assign status_now = {nest_depth, active_depth, active_prio};
    assign branch_now = {branch_vec, branch_addr};
    irq_link_checker irq_link_checker_inst (.mclk(mclk), .rst(rst),
        .irq_req(link.irq_req), .irq_num(link.irq_num),
        .isr_addr(link.isr_addr), .reti(link.reti),
        .request_acknowledge(link.request_acknowledge));
    always #5 mclk = ~mclk;
    // Random boundaries vary the acknowledge delay
    always @(posedge mclk) instr_boundary <= 1'($urandom);
    // ****************
    // Scoreboard
    // ****************
    task automatic check(input string what, input logic [20:0] seen,
            input logic [20:0] want);
        samples_checked++;
        if (seen !== want) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, want, seen);
        end
    endtask : check
    always @(posedge mclk) begin
        if (branch_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("branch count", 21'h1, 21'h0);
            end else begin
                check("branch", branch_now, exp_q[0]);
                void'(exp_q.pop_front());
            end
        end
        if (return_valid === 1'b1) begin
            back++;
            if (ret_q.size() == 0) begin
                check("return count", 21'h1, 21'h0);
            end else begin
                check("return pc", 21'(return_pc), 21'(ret_q[0]));
                void'(ret_q.pop_front());
            end
        end
        // Completion shows the status of the level returned to
        if (routine_complete === 1'b1) begin
            if (done_q.size() == 0) begin
                check("complete count", 21'h1, 21'h0);
            end else begin
                check("restored", 21'(status_now), done_q[0]);
                void'(done_q.pop_front());
            end
        end
    end
    // ****************
    // Drivers
    // ****************
    task automatic wait_for(ref int cnt, input int want);
        for (int i = 0; i < 80 && cnt < want; i++) @(posedge mclk);
        if (cnt < want) check("handshake", 21'h0, 21'h1);
    endtask : wait_for
    // Returns two edges after the branch pulse, so flags can be timed
    task automatic serve(input int v);
        exp_q.push_back({vec_t'(v), vec_addr[v]});
        act_stk.push_back(vec_prio[v]);
        for (int i = 0; i < 80 && branch_valid !== 1'b1; i++)
            @(posedge mclk);
        if (branch_valid !== 1'b1) check("branch", 21'h0, 21'h1);
        pc_stk.push_back(next_pc);
        @(posedge mclk);
        check("pending acked", 21'(pending_flag[v]), 21'h0);
        check("posted acked", 21'(posted_flag[v]), 21'h1);
        @(posedge mclk);
        check("posted cleared", 21'(posted_flag[v]), 21'h0);
    endtask : serve
    task automatic retire();
        int b;
        prio_t exp_p;
        depth_t d;
        b = back;
        ret_q.push_back(pc_stk.pop_back());
        void'(act_stk.pop_back());
        d = depth_t'(act_stk.size());
        exp_p = (act_stk.size() == 0) ? PRIO_LOWEST : act_stk[$];
        done_q.push_back(21'({d, d, exp_p}));
        // Let the acknowledge hold run out first
        repeat (10) @(posedge mclk);
        reti_exec <= 1'b1;
        @(posedge mclk);
        reti_exec <= 1'b0;
        wait_for(back, b + 1);
        next_pc <= addr_t'($urandom);
    endtask : retire
    task automatic pulse(input bit clr, input int v);
        @(posedge mclk);
        if (clr) sw_clear[v] <= 1'b1;
        else sw_set[v] <= 1'b1;
        @(posedge mclk);
        sw_clear[v] <= 1'b0;
        sw_set[v] <= 1'b0;
    endtask : pulse
    task automatic poke(input int src, input int v, input logic lvl);
        case (src)
            0: fixed_lines[v] <= lvl;
            1: if (v < HALF_VEC) dma_terminal_low_bus[v] <= lvl;
               else dma_terminal_high_bus[v - HALF_VEC] <= lvl;
            2: logic_array_bus[v] <= lvl;
            default: sw_set[v] <= lvl;
        endcase
    endtask : poke
    task automatic fire(input int src, input int v);
        @(posedge mclk);
        vec_source[v] <= src_t'(src);
        @(posedge mclk);
        poke(src, v, 1'b1);
        @(posedge mclk);
        if (src == 3) poke(src, v, 1'b0);
        for (int i = 0; i < 6 && pending_flag[v] !== 1'b1; i++) @(posedge mclk);
        check("pending", 21'(pending_flag[v]), 21'h1);
        check("posted early", 21'(posted_flag[v]), 21'h0);
        @(posedge mclk);
        check("posted", 21'(posted_flag[v]), 21'h1);
        // Idle edge plus two evaluation edges before the request
        repeat (2) @(posedge mclk);
        check("early request", 21'(link.irq_req), 21'h0);
        @(posedge mclk);
        check("request", 21'(link.irq_req), 21'h1);
        check("vector", 21'(link.irq_num), 21'(v));
        serve(v);
        retire();
        poke(src, v, 1'b0);
        vec_source[v] <= 2'h3;
    endtask : fire
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    // ****************
    // Tests
    // ****************
    initial begin
        int seed;
        seed = $urandom(32'h3F8D);
        for (int i = 0; i < NUM_VEC; i++) vec_addr[i] = addr_t'($urandom);
        next_pc = addr_t'($urandom);
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            foreach (edge_v[k]) fire(s, edge_v[k]);
            fire(s, $urandom_range(31, 0));
        end
        $display("test sources done");
        @(posedge mclk);
        vec_enable <= '0;
        vec_prio[3] <= 3'h5;
        vec_prio[9] <= 3'h1;
        vec_prio[12] <= 3'h1;
        sw_set <= 32'h0000_1208;
        @(posedge mclk);
        sw_set <= '0;
        repeat (6) @(posedge mclk);
        vec_enable <= '1;
        serve(9);
        retire();
        serve(12);
        retire();
        serve(3);
        retire();
        $display("test priority done");
        vec_prio[20] <= 3'h4;
        vec_prio[25] <= 3'h2;
        vec_prio[28] <= 3'h6;
        pulse(0, 20);
        serve(20);
        next_pc <= addr_t'($urandom);
        pulse(0, 28);
        pulse(0, 25);
        serve(25);
        retire();
        retire();
        serve(28);
        retire();
        $display("test nesting done");
        vec_enable[7] <= 1'b0;
        pulse(0, 7);
        repeat (12) @(posedge mclk);
        check("held pending", 21'(pending_flag[7]), 21'h1);
        pulse(1, 7);
        repeat (3) @(posedge mclk);
        check("cleared pending", 21'(pending_flag[7]), 21'h0);
        vec_enable[7] <= 1'b1;
        repeat (20) @(posedge mclk);
        $display("test clear done");
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        complete_run();
    end
endmodule : vectored_interrupt_controller_bench
